// ---- rtl/pau_flags.sv ----
`timescale 1ns/10ps
`default_nettype none
module pau_flags
  import pau_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] set_i,
  input  wire logic [7:0] clr_i,
  output logic      [7:0] flags_o
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  // Set wins over clear so a coincident event is never lost.
  assign flags_d = (flags_q & ~clr_i) | set_i; // [R16]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
    end
  end
  assign flags_o = flags_q;
endmodule
`default_nettype wire

// ---- rtl/pau_hold.sv ----
`timescale 1ns/10ps
`default_nettype none
module pau_hold
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load_i,
  input  wire logic [7:0] cycles_i,
  input  wire logic       used_i,
  output logic            open_o,
  output logic            expire_o
);
  logic [7:0] cnt_q;
  logic       open_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 8'h00;
      open_q <= 1'b0;
    end else if (load_i) begin
      cnt_q  <= cycles_i; // [R26]
      open_q <= (cycles_i != 8'h00);
    end else if (open_q && used_i) begin
      open_q <= 1'b0; // [R1]
    end else if (open_q) begin
      cnt_q  <= cnt_q - 8'h01; // [R26]
      open_q <= (cnt_q != 8'h01);
    end
  end
  assign open_o   = open_q;
  assign expire_o = open_q && !used_i && !load_i && (cnt_q == 8'h01); // [R15]
endmodule
`default_nettype wire

// ---- rtl/pau_regs.sv ----
// What this block does
// R1 - Unlock lasts hold cycles or one access.
// R2 - Unlock needs matching key value.
// R3 - High enable bits gate channels 32 up.
// R4 - Low enable bits gate channels; reset zero.
// R5 - Idle clears on access, sets when done.
// R6 - Setup status bit follows setup mode.
// R7 - Enabled status bit follows unit enable.
// R8 - Bad remap upper half sets error.
// R9 - Slave bus error sets master error.
// R10 - Unlock with errors aborts, sets blocked.
// R11 - Wrong key sets bad-key flag.
// R12 - Reading unlock port sets read error.
// R13 - Locked access while enabled, outside setup, sets failed.
// R14 - Access after unlock sets succeeded.
// R15 - Unused unlock window sets expired flag.
// R16 - Clear register ones clear status flags.
// R17 - Enable-set ones set mask bits.
// R18 - Enable-clear ones clear mask bits.
// R19 - Mask register reads enabled sources.
// R20 - Info register reports channel count.
// R21 - Revision register returns fixed number.
// R22 - Interrupt when flag and mask both set.
// R23 - Error flags exclude access-succeeded.
// R24 - Channel number written in unlock port.
// R25 - Setup command bit enters setup mode.
// R26 - Down-counter times the unlock window.
// R27 - Reserved bits read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none
module pau_regs
  import pau_pkg::*;
#(
  parameter int CHANNELS = 16
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire pau_req_s    cfg_req,
  output logic      [31:0] cfg_rdata,
  input  wire pau_req_s    chn_req,
  output logic      [31:0] chn_rdata,
  output logic             chn_error,
  output logic             mst_start,
  output logic      [31:0] mst_addr,
  output logic             mst_write,
  output logic      [31:0] mst_wdata,
  input  wire logic        mst_done,
  input  wire logic        mst_berr,
  input  wire logic [31:0] mst_rdata,
  output logic             chn_done,
  output logic             irq
);
  localparam int CW = $clog2(CHANNELS);
  logic [31:0] ceh_q;
  logic [31:0] cel_q;
  logic [7:0]  mask_q;
  logic        en_q;
  logic        setup_q;
  logic        berren_q;
  logic [7:0]  key_q;
  logic [7:0]  unlock_hold_cycles_q;
  logic [31:0] remap_q [CHANNELS];
  logic [5:0]  ul_chan_q;
  logic        busy_q;
  logic        idle_q;
  logic [31:0] rdata_q;
  logic [31:0] chn_rdata_q;
  logic        chn_error_q;
  logic        chn_done_q;
  logic [31:0] mst_addr_q;
  logic        mst_write_q;
  logic [31:0] mst_wdata_q;
  logic        mst_start_q;
  logic [7:0]  flags;
  logic [7:0]  fl_set;
  logic [7:0]  fl_clr;
  logic        ctl_wr;
  logic        cfg_wr;
  logic        ul_wr;
  logic        ul_rd;
  logic        rmp_wr;
  logic        ch_acc;
  logic [5:0]  acc_chan;
  logic        chan_en;
  logic        key_ok;
  logic        err_any;
  logic        unlock_go;
  logic        win_open;
  logic        win_exp;
  logic        acc_ok;
  logic        acc_bad;
  logic [63:0] en_vec;
  logic [31:0] cfg_mux;
  logic [31:0] stat_word;
  logic [7:0]  win_age_q;
  logic [7:0]  win_len_q;

  assign ctl_wr   = cfg_req.wr && (cfg_req.addr == PAU_OFS_CTRL);
  assign cfg_wr   = cfg_req.wr && (cfg_req.addr == PAU_OFS_CONFIG);
  assign ul_wr    = chn_req.wr && (chn_req.addr == PAU_OFS_UNLOCK);
  assign ul_rd    = chn_req.rd && (chn_req.addr == PAU_OFS_UNLOCK); // [R12]
  assign acc_chan = chn_req.addr[7:2];
  assign rmp_wr   = chn_req.wr && setup_q && !ul_wr && (acc_chan < 6'(CHANNELS));
  assign ch_acc   = (chn_req.wr || chn_req.rd) && !setup_q && en_q && !ul_wr && !ul_rd && !busy_q;
  assign en_vec   = {ceh_q & 32'h7FFFFFFF, cel_q}; // [R3] [R4]
  assign chan_en  = en_vec[acc_chan] && (acc_chan < 6'(CHANNELS));
  assign acc_ok   = ch_acc && chan_en && win_open && (ul_chan_q == acc_chan); // [R14]
  assign acc_bad  = ch_acc && !acc_ok; // [R13]
  assign key_ok   = chn_req.wdata[15:8] == key_q; // [R2]
  assign err_any  = |(flags & PAU_ERR_MASK); // [R23]
  assign unlock_go = ul_wr && en_q && !setup_q && key_ok && !err_any; // [R2]

  always_comb begin
    fl_set = 8'h00;
    fl_set[PAU_BIT_EXP]  = win_exp; // [R15]
    fl_set[PAU_BIT_OK]   = acc_ok; // [R14]
    fl_set[PAU_BIT_FAIL] = acc_bad; // [R13]
    fl_set[PAU_BIT_URD]  = ul_rd; // [R12]
    fl_set[PAU_BIT_KEY]  = ul_wr && !err_any && !key_ok; // [R11]
    fl_set[PAU_BIT_BLK]  = ul_wr && err_any; // [R10]
    fl_set[PAU_BIT_MBE]  = mst_done && mst_berr; // [R9]
    fl_set[PAU_BIT_RMP]  = rmp_wr && (chn_req.wdata[31:18] != PAU_RMP_BASE[15:2]); // [R8]
  end
  assign fl_clr = (cfg_req.wr && cfg_req.addr == PAU_OFS_SFC) ? cfg_req.wdata[7:0] : 8'h00; // [R16]

  pau_flags u_flags (
    .clk     (clk),
    .rst     (rst),
    .set_i   (fl_set),
    .clr_i   (fl_clr),
    .flags_o (flags)
  );

  pau_hold u_hold (
    .clk      (clk),
    .rst      (rst),
    .load_i   (unlock_go),
    .cycles_i (unlock_hold_cycles_q),
    .used_i   (acc_ok),
    .open_o   (win_open),
    .expire_o (win_exp)
  );

  assign stat_word = {21'h0, idle_q, setup_q, en_q, flags}; // [R5] [R6] [R7]

  assign cfg_mux = (cfg_req.addr == PAU_OFS_CEH)  ? {1'b0, ceh_q[30:0]} :
                   (cfg_req.addr == PAU_OFS_CEL)  ? cel_q :
                   (cfg_req.addr == PAU_OFS_STAT) ? stat_word :
                   (cfg_req.addr == PAU_OFS_IMS)  ? {24'h0, mask_q} : // [R19]
                   (cfg_req.addr == PAU_OFS_INFO) ? 32'(CHANNELS) : // [R20]
                   (cfg_req.addr == PAU_OFS_REV)  ? {20'h0, PAU_REVISION} : // [R21]
                   32'h00000000; // [R27]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ceh_q    <= 32'h00000000;
      cel_q    <= 32'h00000000;
      mask_q   <= 8'h00;
      en_q     <= 1'b0;
      setup_q  <= 1'b0;
      berren_q <= 1'b0;
      key_q    <= 8'h00;
      unlock_hold_cycles_q   <= 8'h00;
      rdata_q  <= 32'h00000000;
    end else begin
      if (cfg_req.wr && cfg_req.addr == PAU_OFS_CEH) begin
        ceh_q <= {1'b0, cfg_req.wdata[30:0]}; // [R3]
      end
      if (cfg_req.wr && cfg_req.addr == PAU_OFS_CEL) begin
        cel_q <= cfg_req.wdata; // [R4]
      end
      if (cfg_req.wr && cfg_req.addr == PAU_OFS_IES) begin
        mask_q <= mask_q | cfg_req.wdata[7:0]; // [R17]
      end else if (cfg_req.wr && cfg_req.addr == PAU_OFS_IEC) begin
        mask_q <= mask_q & ~cfg_req.wdata[7:0]; // [R18]
      end
      if (ctl_wr && cfg_req.wdata[PAU_CB_EN]) begin
        en_q <= 1'b1; // [R7]
      end else if (ctl_wr && cfg_req.wdata[PAU_CB_DIS]) begin
        en_q <= 1'b0; // [R7]
      end
      if (ctl_wr && cfg_req.wdata[PAU_CB_SEN]) begin
        setup_q <= 1'b1; // [R25] [R6]
      end else if (ctl_wr && cfg_req.wdata[PAU_CB_SDIS]) begin
        setup_q <= 1'b0; // [R6]
      end
      if (ctl_wr && cfg_req.wdata[4]) begin
        berren_q <= 1'b1;
      end else if (ctl_wr && cfg_req.wdata[5]) begin
        berren_q <= 1'b0;
      end
      if (cfg_wr) begin
        key_q  <= cfg_req.wdata[7:0];
        unlock_hold_cycles_q <= cfg_req.wdata[15:8];
      end
      rdata_q <= cfg_req.rd ? cfg_mux : 32'h00000000;
    end
  end

  // Remap targets have no reset value, so they hold no reset branch.
  for (genvar g = 0; g < CHANNELS; g++) begin : g_remap
    always_ff @(posedge clk) begin
      if (rmp_wr && acc_chan == 6'(g)) begin
        remap_q[g] <= chn_req.wdata;
      end
    end
  end

  // Only one forwarded access is outstanding; a new one while busy is refused.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ul_chan_q   <= 6'h00;
      busy_q      <= 1'b0;
      idle_q      <= 1'b1;
      mst_start_q <= 1'b0;
      mst_addr_q  <= 32'h00000000;
      mst_write_q <= 1'b0;
      mst_wdata_q <= 32'h00000000;
      chn_rdata_q <= 32'h00000000;
      chn_error_q <= 1'b0;
      chn_done_q  <= 1'b0;
    end else begin
      mst_start_q <= acc_ok;
      chn_done_q  <= 1'b0;
      chn_error_q <= 1'b0;
      if (unlock_go) begin
        ul_chan_q <= chn_req.wdata[5:0]; // [R24]
      end
      if (acc_ok) begin
        busy_q      <= 1'b1;
        idle_q      <= 1'b0; // [R5]
        mst_addr_q  <= remap_q[acc_chan[CW-1:0]];
        mst_write_q <= chn_req.wr;
        mst_wdata_q <= chn_req.wdata;
      end else if (busy_q && mst_done) begin
        busy_q      <= 1'b0;
        idle_q      <= 1'b1; // [R5]
        chn_rdata_q <= mst_rdata;
        chn_done_q  <= 1'b1;
        chn_error_q <= mst_berr && berren_q;
      end else if (acc_bad || ul_rd) begin
        chn_done_q  <= 1'b1;
        chn_error_q <= berren_q;
      end else if (chn_req.wr || chn_req.rd) begin
        chn_done_q  <= 1'b1;
      end
    end
  end

  assign cfg_rdata = rdata_q;
  assign chn_rdata = chn_rdata_q;
  assign chn_error = chn_error_q;
  assign chn_done  = chn_done_q;
  assign mst_start = mst_start_q;
  assign mst_addr  = mst_addr_q;
  assign mst_write = mst_write_q;
  assign mst_wdata = mst_wdata_q;
  assign irq       = |(flags & mask_q); // [R22]

  // The window length is captured at unlock, so a later hold-count rewrite cannot upset the check.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_age_q <= 8'h00;
      win_len_q <= 8'h00;
    end else if (unlock_go) begin
      win_age_q <= 8'h01;
      win_len_q <= unlock_hold_cycles_q;
    end else if (win_open) begin
      win_age_q <= win_age_q + 8'h01;
    end
  end

  AST_IRQ_MASK: assert property (@(posedge clk) disable iff (rst) // [R22]
    ((|(fl_set & mask_q)) && !(cfg_req.wr && cfg_req.addr == PAU_OFS_IEC)) |=> irq)
    else $error("irq does not follow flags and mask");
  AST_IES: assert property (@(posedge clk) disable iff (rst)
    (cfg_req.wr && cfg_req.addr == PAU_OFS_IES) |=> ((mask_q & $past(cfg_req.wdata[7:0])) == $past(cfg_req.wdata[7:0]))) // [R17]
    else $error("mask set failed");
  AST_IEC: assert property (@(posedge clk) disable iff (rst)
    (cfg_req.wr && cfg_req.addr == PAU_OFS_IEC) |=> ((mask_q & $past(cfg_req.wdata[7:0])) == 8'h00)) // [R18]
    else $error("mask clear failed");
  AST_URD: assert property (@(posedge clk) disable iff (rst) ul_rd |=> flags[PAU_BIT_URD]) // [R12]
    else $error("unlock read flag missing");
  AST_BLK: assert property (@(posedge clk) disable iff (rst) // [R10]
    (ul_wr && err_any) |=> (flags[PAU_BIT_BLK] && (!win_open || $past(win_open))))
    else $error("blocked unlock not flagged");
  AST_FAIL: assert property (@(posedge clk) disable iff (rst) acc_bad |=> flags[PAU_BIT_FAIL]) // [R13]
    else $error("failed access not flagged");
  AST_OK: assert property (@(posedge clk) disable iff (rst) acc_ok |=> (flags[PAU_BIT_OK] && !win_open && !idle_q)) // [R14]
    else $error("success access not handled");
  sequence s_unlock;
    unlock_go && (unlock_hold_cycles_q != 8'h00);
  endsequence
  AST_OPEN: assert property (@(posedge clk) disable iff (rst) s_unlock |=> win_open) // [R1]
    else $error("unlock did not open window");
  AST_EXP: assert property (@(posedge clk) disable iff (rst) win_exp |=> (!win_open && flags[PAU_BIT_EXP])) // [R15]
    else $error("expiry not flagged");
  AST_IDLE: assert property (@(posedge clk) disable iff (rst) (busy_q && mst_done) |=> idle_q) // [R5]
    else $error("idle not restored");
  AST_SFC: assert property (@(posedge clk) disable iff (rst) // [R16]
    (cfg_req.wr && cfg_req.addr == PAU_OFS_SFC) |=> ((flags & $past(cfg_req.wdata[7:0] & ~fl_set)) == 8'h00))
    else $error("status flag clear failed");
  AST_RMP: assert property (@(posedge clk) disable iff (rst) // [R8]
    (rmp_wr && (chn_req.wdata[31:16] < PAU_RMP_BASE)) |=> flags[PAU_BIT_RMP])
    else $error("remap address error missing");
  AST_MBE: assert property (@(posedge clk) disable iff (rst) // [R9]
    (busy_q && mst_done && mst_berr) |=> flags[PAU_BIT_MBE])
    else $error("master bus error not flagged");
  AST_KEY: assert property (@(posedge clk) disable iff (rst) // [R11]
    (ul_wr && !err_any && (chn_req.wdata[15:8] != key_q)) |=> flags[PAU_BIT_KEY])
    else $error("bad key not flagged");
  AST_NOKEY: assert property (@(posedge clk) disable iff (rst) // [R2]
    (ul_wr && !win_open && (chn_req.wdata[15:8] != key_q)) |=> !win_open)
    else $error("window opened on a wrong key");
  AST_SEN: assert property (@(posedge clk) disable iff (rst) // [R25]
    (ctl_wr && cfg_req.wdata[PAU_CB_SEN]) |=> (setup_q && stat_word[PAU_BIT_SETUP]))
    else $error("setup mode not entered");
  AST_SDIS: assert property (@(posedge clk) disable iff (rst) // [R6]
    (ctl_wr && cfg_req.wdata[PAU_CB_SDIS] && !cfg_req.wdata[PAU_CB_SEN]) |=> !stat_word[PAU_BIT_SETUP])
    else $error("setup mode not left");
  AST_EN: assert property (@(posedge clk) disable iff (rst) // [R7]
    (ctl_wr && cfg_req.wdata[PAU_CB_EN]) |=> stat_word[PAU_BIT_EN])
    else $error("enable not shown in status");
  AST_DIS: assert property (@(posedge clk) disable iff (rst) // [R7]
    (ctl_wr && cfg_req.wdata[PAU_CB_DIS] && !cfg_req.wdata[PAU_CB_EN]) |=> !stat_word[PAU_BIT_EN])
    else $error("disable not shown in status");
  AST_CEH: assert property (@(posedge clk) disable iff (rst) // [R3]
    (cfg_req.rd && cfg_req.addr == PAU_OFS_CEH) |=> !cfg_rdata[31])
    else $error("reserved enable bit read back");
  AST_INFO: assert property (@(posedge clk) disable iff (rst) // [R20]
    (cfg_req.rd && cfg_req.addr == PAU_OFS_INFO) |=> (cfg_rdata == 32'(CHANNELS)))
    else $error("channel count not reported");
  AST_REV: assert property (@(posedge clk) disable iff (rst) // [R21]
    (cfg_req.rd && cfg_req.addr == PAU_OFS_REV) |=> (cfg_rdata == {20'h00000, PAU_REVISION}))
    else $error("revision not reported");
  sequence s_reply_in;
    busy_q && mst_done;
  endsequence
  sequence s_reply_out;
    chn_done && idle_q && (chn_rdata == $past(mst_rdata));
  endsequence
  AST_REPLY: assert property (@(posedge clk) disable iff (rst) s_reply_in |=> s_reply_out) // [R5]
    else $error("forwarded reply not returned");
  AST_HOLD: assert property (@(posedge clk) disable iff (rst) win_exp |-> (win_age_q == win_len_q)) // [R1]
    else $error("unlock window length wrong");
endmodule
`default_nettype wire

// ---- shared/pau_pkg.sv ----
`default_nettype none
package pau_pkg;
  localparam logic [7:0] PAU_OFS_CTRL   = 8'h00;
  localparam logic [7:0] PAU_OFS_CONFIG = 8'h04;
  localparam logic [7:0] PAU_OFS_CEH    = 8'h08;
  localparam logic [7:0] PAU_OFS_CEL    = 8'h0C;
  localparam logic [7:0] PAU_OFS_STAT   = 8'h10;
  localparam logic [7:0] PAU_OFS_IES    = 8'h14;
  localparam logic [7:0] PAU_OFS_IEC    = 8'h18;
  localparam logic [7:0] PAU_OFS_IMS    = 8'h1C;
  localparam logic [7:0] PAU_OFS_SFC    = 8'h20;
  localparam logic [7:0] PAU_OFS_INFO   = 8'h24;
  localparam logic [7:0] PAU_OFS_REV    = 8'h28;
  localparam logic [7:0] PAU_OFS_UNLOCK = 8'hFC;
  localparam int         PAU_BIT_EXP    = 0;
  localparam int         PAU_BIT_OK     = 1;
  localparam int         PAU_BIT_FAIL   = 2;
  localparam int         PAU_BIT_URD    = 3;
  localparam int         PAU_BIT_KEY    = 4;
  localparam int         PAU_BIT_BLK    = 5;
  localparam int         PAU_BIT_MBE    = 6;
  localparam int         PAU_BIT_RMP    = 7;
  localparam int         PAU_BIT_EN     = 8;
  localparam int         PAU_BIT_SETUP  = 9;
  localparam int         PAU_BIT_IDLE   = 10;
  localparam int         PAU_CB_EN      = 0;
  localparam int         PAU_CB_DIS     = 1;
  localparam int         PAU_CB_SEN     = 2;
  localparam int         PAU_CB_SDIS    = 3;
  localparam logic [7:0] PAU_ERR_MASK   = 8'hFD;
  localparam logic [11:0] PAU_REVISION  = 12'h111;
  localparam logic [15:0] PAU_RMP_BASE  = 16'hFFFC;
  localparam logic [31:0] PAU_STAT_RST  = 32'h00000400;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } pau_req_s;
endpackage
`default_nettype wire

// ---- testbench/pau_slave_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pau_slave_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  lat,
  input  wire logic        berr_en,
  output logic             done,
  output logic             berr,
  output logic      [31:0] rdata
);
  logic [3:0]  cnt_q;
  logic [31:0] a_q;
  logic [31:0] junk_q;
  // Outside the answer cycle the data churns, so a stale word never passes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      a_q <= 32'h0;
      junk_q <= 32'h0;
    end else begin
      junk_q <= junk_q + 32'h9E3779B9;
      if (start) begin
        cnt_q <= lat;
        a_q <= addr;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
  assign done  = (cnt_q == 4'h1);
  assign berr  = done & berr_en;
  assign rdata = done ? ~a_q : junk_q;
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import pau_pkg::*;
;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [7:0]  ra;
    logic [31:0] e;
  } pau_row_s;
  logic        clk;
  logic        rst;
  pau_req_s    cfg_req;
  pau_req_s    chn_req;
  logic [31:0] cfg_rdata;
  logic [31:0] chn_rdata;
  logic [31:0] mst_addr;
  logic [31:0] mst_wdata;
  logic [31:0] mst_rdata;
  logic [31:0] seen_addr;
  logic [31:0] seen_wdata;
  logic        seen_write;
  logic [31:0] q;
  logic        chn_error;
  logic        mst_start;
  logic        mst_write;
  logic        mst_done;
  logic        mst_berr;
  logic        chn_done;
  logic        irq;
  logic        berr_en;
  logic [3:0]  lat;
  int          miscompares;
  int          comparisons;
  pau_row_s    rows [12];
  pau_regs #(.CHANNELS(16)) uut (.clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .chn_req(chn_req), .chn_rdata(chn_rdata), .chn_error(chn_error), .mst_start(mst_start),
    .mst_addr(mst_addr), .mst_write(mst_write), .mst_wdata(mst_wdata), .mst_done(mst_done),
    .mst_berr(mst_berr), .mst_rdata(mst_rdata), .chn_done(chn_done), .irq(irq));
  pau_slave_model slave (.clk(clk), .rst(rst), .start(mst_start), .addr(mst_addr), .lat(lat),
    .berr_en(berr_en), .done(mst_done), .berr(mst_berr), .rdata(mst_rdata));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (mst_start === 1'b1) begin
      seen_addr  <= mst_addr;
      seen_wdata <= mst_wdata;
      seen_write <= mst_write;
    end
  end
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) cfg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk) cfg_req <= '0;
    #1 q = cfg_rdata;
  endtask
  task automatic chn(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk) chn_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk) chn_req <= '0;
    #1;
    while (chn_done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    check("chn_done", {31'h0, chn_done}, 32'h1);
  endtask
  task automatic stat(input logic [31:0] e);
    cfg(1'b0, PAU_OFS_STAT, 32'h0);
    check("status", q, e);
    cfg(1'b1, PAU_OFS_SFC, 32'hFF);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cfg_req = '0;
    chn_req = '0;
    lat = 4'h6;
    berr_en = 1'b0;
    rows = '{'{1'b0, 8'h00, 32'h0, PAU_OFS_CEH, 32'h0}, '{1'b0, 8'h00, 32'h0, PAU_OFS_CEL, 32'h0},
      '{1'b0, 8'h00, 32'h0, PAU_OFS_STAT, 32'h400}, '{1'b0, 8'h00, 32'h0, PAU_OFS_IMS, 32'h0},
      '{1'b0, 8'h00, 32'h0, PAU_OFS_INFO, 32'h10}, '{1'b0, 8'h00, 32'h0, PAU_OFS_REV, 32'h111},
      '{1'b1, PAU_OFS_CEH, 32'hFFFFFFFF, PAU_OFS_CEH, 32'h7FFFFFFF},
      '{1'b1, PAU_OFS_CEL, 32'h8, PAU_OFS_CEL, 32'h8},
      '{1'b1, PAU_OFS_IES, 32'hFFFFFFFF, PAU_OFS_IMS, 32'hFF},
      '{1'b1, PAU_OFS_IEC, 32'hF, PAU_OFS_IMS, 32'hF0},
      '{1'b1, PAU_OFS_IEC, 32'hFF, PAU_OFS_IMS, 32'h0}, '{1'b0, 8'h00, 32'h0, 8'h2C, 32'h0}};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) cfg(1'b1, rows[i].a, rows[i].d);
      cfg(1'b0, rows[i].ra, 32'h0);
      check("register", q, rows[i].e);
    end
    $display("test registers done");
    cfg(1'b1, PAU_OFS_CTRL, 32'h1);
    cfg(1'b1, PAU_OFS_CTRL, 32'h4);
    cfg(1'b0, PAU_OFS_STAT, 32'h0);
    check("setup status", q, 32'h700);
    chn(1'b1, 8'h0C, 32'h12340000);
    chn(1'b1, 8'h0C, 32'hFFFC0100);
    cfg(1'b1, PAU_OFS_CTRL, 32'h8);
    stat(32'h580);
    cfg(1'b1, PAU_OFS_CONFIG, 32'h85A);
    stat(32'h500);
    $display("test setup done");
    chn(1'b0, 8'h0C, 32'h0);
    stat(32'h504);
    chn(1'b1, PAU_OFS_UNLOCK, 32'hA503);
    chn(1'b1, PAU_OFS_UNLOCK, 32'h5A03);
    stat(32'h530);
    $display("test refusals done");
    chn(1'b1, PAU_OFS_UNLOCK, 32'h5A03);
    fork
      chn(1'b0, 8'h0C, 32'h0);
      begin
        repeat (2) @(posedge clk);
        cfg(1'b0, PAU_OFS_STAT, 32'h0);
        check("idle busy", {31'h0, q[PAU_BIT_IDLE]}, 32'h0);
      end
    join
    check("target", seen_addr, 32'hFFFC0100);
    check("read data", chn_rdata, 32'h0003FEFF);
    check("read direction", {31'h0, seen_write}, 32'h0);
    chn(1'b0, 8'h0C, 32'h0);
    stat(32'h506);
    $display("test access done");
    lat = 4'h1;
    chn(1'b1, PAU_OFS_UNLOCK, 32'h5A03);
    repeat (20) @(posedge clk);
    stat(32'h501);
    chn(1'b0, PAU_OFS_UNLOCK, 32'h0);
    stat(32'h508);
    $display("test expiry done");
    berr_en = 1'b1;
    cfg(1'b1, PAU_OFS_CTRL, 32'h10);
    chn(1'b1, PAU_OFS_UNLOCK, 32'h5A03);
    chn(1'b1, 8'h0C, 32'hA5A50F0F);
    check("error response", {31'h0, chn_error}, 32'h1);
    check("write direction", {31'h0, seen_write}, 32'h1);
    check("write data", seen_wdata, 32'hA5A50F0F);
    cfg(1'b1, PAU_OFS_IES, 32'h40);
    check("irq on", {31'h0, irq}, 32'h1);
    cfg(1'b0, PAU_OFS_STAT, 32'h0);
    check("bus error", {31'h0, q[PAU_BIT_MBE]}, 32'h1);
    cfg(1'b1, PAU_OFS_SFC, 32'h40);
    check("irq off", {31'h0, irq}, 32'h0);
    $display("test bus error done");
    cfg(1'b1, PAU_OFS_CTRL, 32'h22);
    stat(32'h402);
    chn(1'b0, PAU_OFS_UNLOCK, 32'h0);
    check("error response off", {31'h0, chn_error}, 32'h0);
    $display("test disable done");
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cfg(1'b0, PAU_OFS_CEL, 32'h0);
    check("enable after reset", q, 32'h0);
    stat(32'h400);
    $display("test reset done");
    give_verdict();
  end
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
